// ==== src/cmt_consts.svh ====
// constants of the compare match toggle timer
//
// Function
// - on each compare match A, invert the output level when toggle mode is selected
// - clear-on-match-A resets the counter to zero on compare match A
// - with clear-on-match-A, match interval is compare value plus one count source periods
// - output starts at a software-selected initial level before the first match
// - optional mode: compare register C buffers compare register A
// - counter keeps counting after a match, it does not halt
// - optional forced cut-off disables the output while the cut-off input is low
// - timer can raise an A/D start trigger, which software may disable
// - the output appears on a shared port pin set as an output
// - the undivided system clock can be the count source
// - output enable off means the pin does not carry the waveform
// - count source field value 000 selects the undivided clock
// - count start bit 0 makes the counter hold its value
// - initial level bit 0 selects a low initial level
`ifndef CMT_CONSTS_SVH
`define CMT_CONSTS_SVH

`define CMT_CNT_WIDTH      16
`define CMT_CNT_RESET      16'h0000
`define CMT_CMP_RESET      16'hFFFF
`define CMT_SRC_UNDIVIDED  3'h0
`define CMT_SRC_DIV2       3'h1
`define CMT_SRC_DIV4       3'h2
`define CMT_SRC_DIV8       3'h3
`define CMT_SRC_DIV32      3'h4

`endif

// ==== src/cmt_pkg.sv ====
// types of the compare match toggle timer
package cmt_pkg;
    typedef enum logic [1:0]
    {
        CMT_STOPPED = 2'b00,
        CMT_RUNNING = 2'b01
    } cmt_state_t;
endpackage

// ==== src/cmt_prescaler.sv ====
// count source prescaler: one-cycle count enable pulses
`timescale 1ns/100ps
`include "cmt_consts.svh"
module cmt_prescaler
    import cmt_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       run,
    input  wire logic [2:0] count_src_sel,
    output logic            count_tick
);
    logic [4:0] div_count;

    // ==========================================================
    // divider
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            div_count <= 5'h00;
        else if (!run)
            div_count <= 5'h00;
        else
            div_count <= div_count + 5'h01;
    end

    always_comb
    begin
        unique case (count_src_sel)
            `CMT_SRC_UNDIVIDED: count_tick = run;
            `CMT_SRC_DIV2:      count_tick = run && (div_count[0] == 1'b1);
            `CMT_SRC_DIV4:      count_tick = run && (div_count[1:0] == 2'h3);
            `CMT_SRC_DIV8:      count_tick = run && (div_count[2:0] == 3'h7);
            `CMT_SRC_DIV32:     count_tick = run && (div_count == 5'h1F);
            // unused codes stop the count source
            default:            count_tick = 1'b0;
        endcase
    end
endmodule

// ==== src/cmt_timer.sv ====
// compare match toggle timer top
`timescale 1ns/100ps
`include "cmt_consts.svh"
module cmt_timer
    import cmt_pkg::*;
#(
    parameter int CNT_WIDTH = `CMT_CNT_WIDTH
)
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 count_start,
    input  wire logic                 count_src_sel_b0,
    input  wire logic                 count_src_sel_b1,
    input  wire logic                 count_src_sel_b2,
    input  wire logic                 counter_clear_select,
    input  wire logic                 initial_level_a_bit,
    input  wire logic                 toggle_on_match,
    input  wire logic                 buffer_mode_c,
    input  wire logic                 output_enable_a,
    input  wire logic                 cutoff_enable,
    input  wire logic                 forced_cutoff_input,
    input  wire logic                 adc_trigger_enable,
    input  wire logic                 port_select_compare,
    input  wire logic                 port_data_out,
    input  wire logic                 compare_a_write,
    input  wire logic [CNT_WIDTH-1:0] compare_a_wdata,
    input  wire logic                 compare_c_write,
    input  wire logic [CNT_WIDTH-1:0] compare_c_wdata,
    output logic [CNT_WIDTH-1:0]      timer_count_value,
    output logic [CNT_WIDTH-1:0]      compare_reg_a,
    output logic [CNT_WIDTH-1:0]      compare_reg_c,
    output logic                      compare_out_a_pin,
    output logic                      shared_port_pin,
    output logic                      shared_port_pin_oe,
    output logic                      match_a_flag,
    output logic                      adc_start_trigger
);
    cmt_state_t           state;
    cmt_state_t           next_state;
    logic                 cutoff_meta;
    logic                 cutoff_sync;
    logic                 count_tick;
    logic                 match_a;
    logic                 run;
    logic                 next_out;
    logic                 next_pin;
    logic [CNT_WIDTH-1:0] next_count;
    logic [CNT_WIDTH-1:0] next_reg_a;

    // ==========================================================
    // input synchroniser for the external cut-off pin
    // both stages reset to the idle high level, so reset never looks like a cut-off
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cutoff_meta <= 1'b1;
            cutoff_sync <= 1'b1;
        end
        else
        begin
            cutoff_meta <= forced_cutoff_input;
            cutoff_sync <= cutoff_meta;
        end
    end

    // ==========================================================
    // run state
    // counting needs the start bit on two edges in a row, so a one-cycle blip never counts
    always_comb
    begin
        unique case (state)
            CMT_STOPPED: next_state = count_start ? CMT_RUNNING : CMT_STOPPED;
            CMT_RUNNING: next_state = count_start ? CMT_RUNNING : CMT_STOPPED;
            default:     next_state = CMT_STOPPED;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state <= CMT_STOPPED;
        else
            state <= next_state;
    end

    // dropping the start bit stops the tick at once, without waiting for the state
    assign run = (state == CMT_RUNNING) && count_start;

    // one-cycle tick per count source period; nothing here runs on a slower clock
    cmt_prescaler u_prescaler
    (
        .clk           (clk),
        .reset_n       (reset_n),
        .run           (run),
        .count_src_sel ({count_src_sel_b2, count_src_sel_b1, count_src_sel_b0}),
        .count_tick    (count_tick)
    );

    // match is judged on the count tick so one match spans one clock cycle
    assign match_a = count_tick && (timer_count_value == compare_reg_a);

    // ==========================================================
    // counter
    // clear wins over the tick, so with clear-select the value after a match is zero and never A plus one
    always_comb
    begin
        next_count = timer_count_value;
        if (match_a && counter_clear_select)
            next_count = '0;
        else if (count_tick)
            next_count = timer_count_value + 1'b1;
    end

    // without clear-select the counter simply wraps through its full range
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            timer_count_value <= CNT_WIDTH'(`CMT_CNT_RESET);
        else
            timer_count_value <= next_count;
    end

    // ==========================================================
    // compare registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            compare_reg_c <= CNT_WIDTH'(`CMT_CMP_RESET);
        else if (compare_c_write)
            compare_reg_c <= compare_c_wdata;
    end

    // in buffer mode A loads from C at each match, so a period change never tears
    // a direct write to A in that same cycle is lost; software should write C instead
    always_comb
    begin
        next_reg_a = compare_reg_a;
        if (buffer_mode_c && match_a)
            next_reg_a = compare_reg_c;
        else if (compare_a_write)
            next_reg_a = compare_a_wdata;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            compare_reg_a <= CNT_WIDTH'(`CMT_CMP_RESET);
        else
            compare_reg_a <= next_reg_a;
    end

    // ==========================================================
    // toggle output
    // a stopped timer keeps reloading the initial level, so a restart always begins there
    always_comb
    begin
        next_out = compare_out_a_pin;
        if (!count_start)
            next_out = initial_level_a_bit;
        else if (match_a && toggle_on_match)
            next_out = ~compare_out_a_pin;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            compare_out_a_pin <= 1'b0;
        else
            compare_out_a_pin <= next_out;
    end

    // ==========================================================
    // pin, cut-off and events
    // the pin is judged in one place, so enable, cut-off and port data never fight
    always_comb
    begin
        next_pin = compare_out_a_pin;
        if (!port_select_compare)
            next_pin = port_data_out;
        else if (!output_enable_a)
            next_pin = 1'b0;
        else if (cutoff_enable && !cutoff_sync)
            next_pin = 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            shared_port_pin <= 1'b0;
        else
            shared_port_pin <= next_pin;
    end

    // a plain port always drives; the compare function drives only while enabled
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            shared_port_pin_oe <= 1'b0;
        else
            shared_port_pin_oe <= port_select_compare ? output_enable_a : 1'b1;
    end

    // flag and trigger are registered, so they rise on the edge that toggles the output
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            match_a_flag <= 1'b0;
        else
            match_a_flag <= match_a;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            adc_start_trigger <= 1'b0;
        else
            adc_start_trigger <= match_a && adc_trigger_enable;
    end
endmodule

// ==== dv/cmt_timer_checker.sv ====
// port assertions of the compare match toggle timer
`timescale 1ns/100ps
module cmt_timer_checker
#(
    parameter int CNT_WIDTH = 16
)
(
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire logic                 count_start,
    input wire logic                 counter_clear_select,
    input wire logic                 initial_level_a_bit,
    input wire logic                 toggle_on_match,
    input wire logic                 output_enable_a,
    input wire logic                 cutoff_enable,
    input wire logic                 forced_cutoff_input,
    input wire logic                 adc_trigger_enable,
    input wire logic                 port_select_compare,
    input wire logic [CNT_WIDTH-1:0] timer_count_value,
    input wire logic                 compare_out_a_pin,
    input wire logic                 shared_port_pin,
    input wire logic                 match_a_flag,
    input wire logic                 adc_start_trigger
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ==========
    // sequences
    sequence steady_toggle;
        (toggle_on_match && count_start)[*3];
    endsequence
    // sync stages plus the pin register need four cycles
    sequence cut_held;
        (cutoff_enable && !forced_cutoff_input && port_select_compare)[*4];
    endsequence
    // ==========
    // assertions
    toggle_on_a: assert property (steady_toggle ##0 match_a_flag |->
        compare_out_a_pin != $past(compare_out_a_pin, 2)) else $error("no toggle on match");
    clear_on_a: assert property (match_a_flag && $past(counter_clear_select, 2) |->
        timer_count_value <= 1) else $error("counter not cleared on match");
    count_hold_a: assert property ((!count_start)[*4] |-> $stable(timer_count_value))
        else $error("counter moved while stopped");
    step_one_a: assert property ($changed(timer_count_value) |-> timer_count_value == 0 ||
        timer_count_value == $past(timer_count_value) + 1'b1) else $error("counter jumped");
    init_level_a: assert property ((!count_start && $stable(initial_level_a_bit))[*4] |->
        compare_out_a_pin == initial_level_a_bit) else $error("initial level wrong");
    oe_off_a: assert property ((!output_enable_a && port_select_compare)[*2] |->
        !shared_port_pin) else $error("pin driven while disabled");
    cut_off_a: assert property (cut_held |-> !shared_port_pin)
        else $error("pin not cut off");
    adc_off_a: assert property ((!adc_trigger_enable)[*3] |-> !adc_start_trigger)
        else $error("trigger while disabled");
endmodule
bind cmt_timer cmt_timer_checker #(.CNT_WIDTH(CNT_WIDTH)) cmt_timer_checker_inst (.clk(clk),
    .reset_n(reset_n), .count_start(count_start), .counter_clear_select(counter_clear_select),
    .initial_level_a_bit(initial_level_a_bit), .toggle_on_match(toggle_on_match),
    .output_enable_a(output_enable_a), .cutoff_enable(cutoff_enable),
    .forced_cutoff_input(forced_cutoff_input), .adc_trigger_enable(adc_trigger_enable),
    .port_select_compare(port_select_compare), .timer_count_value(timer_count_value),
    .compare_out_a_pin(compare_out_a_pin), .shared_port_pin(shared_port_pin),
    .match_a_flag(match_a_flag), .adc_start_trigger(adc_start_trigger));

// ==== dv/cmt_edge_watch.sv ====
// far-side model counting level changes on the driven pin
`timescale 1ns/100ps
module cmt_edge_watch
(
    input  wire logic clk,
    input  wire logic pin,
    input  wire logic pin_oe,
    output int        toggles
);
    logic last = 1'b0;
    initial toggles = 0;
    // an undriven pin is not seen, so only changes while pin_oe is high count, port data included
    always @(posedge clk)
    begin
        if (pin_oe && pin !== last)
            toggles <= toggles + 1;
        last <= pin;
    end
endmodule

// ==== dv/cmt_timer_test.sv ====
// self-checking bench of the compare match toggle timer
`timescale 1ns/100ps
module cmt_timer_test;
    logic clk = 0, reset_n = 0, go = 0, s0 = 0, s1 = 0, s2 = 0, lvl = 0, buf_c = 0, oe = 1;
    logic cut_en = 0, cut_n = 1, adc_en = 1, psel = 1, pdat = 0, wa = 0, wc = 0;
    logic clr = 1, tog = 1, o;
    logic [15:0] da = 0, dc = 0, cnt, ra, rc;
    logic out_a, pin, pin_oe, flag, trig;
    int n_mismatch = 0, total_checks = 0, seed = 32'h4EFC130D, toggles, i, n, c, t0;
    int dv[5] = '{1, 2, 4, 8, 32};
    always #25 clk = ~clk;
    cmt_timer cmt_timer_inst (.clk(clk), .reset_n(reset_n), .count_start(go),
        .count_src_sel_b0(s0), .count_src_sel_b1(s1), .count_src_sel_b2(s2),
        .counter_clear_select(clr), .initial_level_a_bit(lvl), .toggle_on_match(tog),
        .buffer_mode_c(buf_c), .output_enable_a(oe), .cutoff_enable(cut_en),
        .forced_cutoff_input(cut_n), .adc_trigger_enable(adc_en), .port_select_compare(psel),
        .port_data_out(pdat), .compare_a_write(wa), .compare_a_wdata(da),
        .compare_c_write(wc), .compare_c_wdata(dc), .timer_count_value(cnt),
        .compare_reg_a(ra), .compare_reg_c(rc), .compare_out_a_pin(out_a),
        .shared_port_pin(pin), .shared_port_pin_oe(pin_oe), .match_a_flag(flag),
        .adc_start_trigger(trig));
    cmt_edge_watch cmt_edge_watch_inst (.clk(clk), .pin(pin), .pin_oe(pin_oe),
        .toggles(toggles));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_flag(output int cyc);
        cyc = 0;
        do
        begin
            @(negedge clk);
            cyc++;
        end while (flag !== 1'b1 && cyc < 3000);
    endtask
    task automatic settle(input int k);
        repeat (k) @(negedge clk);
    endtask
    initial
    begin
        #2000000;
        n_mismatch++;
        summarize();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        reset_n <= 1;
        // counter is at most two when the new limit lands, so a limit of two or more never wraps
        for (i = 0; i < 5; i++)
        begin
            n = 2 + {$random(seed)} % 5;
            @(posedge clk);
            {s2, s1, s0} <= 3'(i);
            da <= 16'(n);
            wa <= 1;
            @(posedge clk);
            wa <= 0;
            go <= 1;
            wait_flag(c);
            t0 = toggles;
            check("compare_reg_a", ra, n);
            wait_flag(c);
            check("interval", c, (n + 1) * dv[i]);
            check("toggles", toggles, t0 + 1);
            check("adc_trigger", trig, 1);
        end
        @(posedge clk);
        go <= 0;
        lvl <= 1;
        settle(6);
        check("initial_level", out_a, 1);
        c = cnt;
        settle(4);
        check("held_count", cnt, c);
        check("pin_driven", pin, 1);
        @(posedge clk);
        oe <= 0;
        settle(3);
        check("pin_disabled", pin, 0);
        check("pin_oe_off", pin_oe, 0);
        @(posedge clk);
        oe <= 1;
        cut_en <= 1;
        cut_n <= 0;
        settle(6);
        check("pin_cut", pin, 0);
        @(posedge clk);
        cut_en <= 0;
        settle(4);
        check("pin_uncut", pin, 1);
        @(posedge clk);
        psel <= 0;
        pdat <= 1'($random(seed));
        settle(3);
        check("port_data", pin, pdat);
        check("port_oe", pin_oe, 1);
        @(posedge clk);
        {buf_c, adc_en, lvl, psel, s2, s1, s0} <= 7'b0000000;
        {da, dc, wa, wc} <= {16'h0007, 16'h0003, 2'b11};
        @(posedge clk);
        {wa, wc, go} <= 3'b001;
        buf_c <= 1;
        wait_flag(c);
        check("adc_trigger_off", trig, 0);
        wait_flag(c);
        check("buffered_interval", c, 4);
        check("buffered_reg_a", ra, 3);
        check("buffered_reg_c", rc, 3);
        @(posedge clk);
        tog <= 0;
        @(posedge clk);
        clr <= 0;  // output control went first, so no two-clock wait is owed
        o = out_a;
        wait_flag(c);
        check("no_clear", cnt, 4);
        check("no_toggle", out_a, o);
        summarize();
    end
endmodule
